// ### rtl/onchip_debug_pkg.sv
// Operation
// - JTAG port stays disabled unless the jtag_port_fuse is programmed.
// - Debug works only with debug_enable_fuse programmed and no lock bit set.
// - Instruction codes 0x8 to 0xB select the debug access instructions.
// - CPU write stores byte for debugger and sets debug_reg_dirty together.
// - CPU read returns low seven bits with debug_reg_dirty in bit seven.
// - Two data break points, or both combined as one masked range.
// - Break instruction acts as code break point handing control to debugger.
`default_nettype none
package onchip_debug_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] CommRegAddr  = 6'h22;
    localparam logic [7:0] CommRegReset = 8'h00;
    localparam int         DirtyBit     = 7;
    // ------------------------------------------------------------
    // Instruction register and data address width
    // ------------------------------------------------------------
    localparam int         IrWidth      = 4;
    localparam logic [3:0] InstrAccess0 = 4'h8;
    localparam logic [3:0] InstrAccess1 = 4'h9;
    localparam logic [3:0] InstrAccess2 = 4'ha;
    localparam logic [3:0] InstrAccess3 = 4'hb;
    localparam int         AddrWidth    = 16;
    // ------------------------------------------------------------
    // Debugger command codes on the access chain
    // ------------------------------------------------------------
    localparam logic [1:0] CmdReadComm  = 2'h0;
    localparam logic [1:0] CmdWriteBrk  = 2'h1;
    localparam logic [1:0] CmdCtrl      = 2'h2;
endpackage
`default_nettype wire

// ### rtl/onchip_debug_channel.sv
`default_nettype none
module onchip_debug_channel (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // Fuses and lock bits
    input  wire logic                  jtagPortFuse,
    input  wire logic                  debugEnableFuse,
    input  wire logic [1:0]            lockBits,
    // JTAG pins
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    output logic                       tdoEn,
    // TAP state from the test controller
    input  wire logic                  irUpdate,
    input  wire logic                  drShift,
    input  wire logic                  drUpdate,
    // CPU I/O port
    input  wire logic [5:0]            ioAddr,
    input  wire logic                  ioWr,
    input  wire logic                  ioRd,
    input  wire logic [7:0]            ioWdata,
    output logic [7:0]                 ioRdata,
    output logic                       ioHit,
    // CPU debug events
    input  wire logic                  breakInstr,
    input  wire logic                  dataAccess,
    input  wire logic [onchip_debug_pkg::AddrWidth-1:0] dataAddr,
    // Status
    output logic                       tapEnabled,
    output logic                       debugActive,
    output logic                       debugAccessSel,
    output logic                       cpuHalt
);
    import onchip_debug_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Link clock must stay well below clk/4: each half period needs three clk edges
    logic [3:0] syncA_q, syncB_q, syncA_d, syncB_d;
    logic       tckPrev_q, tckPrev_d;
    logic       tckRise, tckFall;
    always_comb begin
        syncA_d   = {drShift, tck, tms, tdi};
        syncB_d   = syncA_q;
        tckPrev_d = syncB_q[2];
    end
    logic [2:0] updA_q, updB_q, updA_d;
    always_comb begin
        updA_d = {irUpdate, drUpdate, 1'b0};
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            syncA_q   <= 4'h0;
            syncB_q   <= 4'h0;
            updA_q    <= 3'h0;
            updB_q    <= 3'h0;
            tckPrev_q <= 1'b0;
        end else begin
            syncA_q   <= syncA_d;
            syncB_q   <= syncB_d;
            updA_q    <= updA_d;
            updB_q    <= updA_q;
            tckPrev_q <= tckPrev_d;
        end
    end
    assign tckRise = syncB_q[2] & ~tckPrev_q;
    assign tckFall = ~syncB_q[2] & tckPrev_q;

    // ------------------------------------------------------------
    // Update strobes
    // ------------------------------------------------------------
    logic [2:0] updC_q, updC_d;
    always_comb begin
        updC_d = updB_q;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            updC_q <= 3'h0;
        end else begin
            updC_q <= updC_d;
        end
    end
    // A held update level would decode the word a capture just loaded as a new command

    // ------------------------------------------------------------
    // Enables
    // ------------------------------------------------------------
    assign tapEnabled  = jtagPortFuse;
    assign debugActive = tapEnabled & debugEnableFuse & ~|lockBits;

    function automatic logic isAccessInstr(input logic [IrWidth-1:0] ir);
        isAccessInstr = (ir == InstrAccess0) | (ir == InstrAccess1) |
                        (ir == InstrAccess2) | (ir == InstrAccess3);
    endfunction

    // ------------------------------------------------------------
    // Shift chain: 2-bit command + 16-bit data, LSB first
    // ------------------------------------------------------------
    logic [17:0] shift_q, shift_d;
    logic [IrWidth-1:0] ir_q, ir_d;
    logic [7:0]  comm_q, comm_d;
    logic        dirty_q, dirty_d;
    logic        ioEn_q, ioEn_d;
    logic        halt_q, halt_d;
    logic        rangeMode_q, rangeMode_d;
    logic [1:0]  brkEn_q, brkEn_d;
    logic [AddrWidth-1:0] brkA_q, brkA_d, brkB_q, brkB_d;
    logic        tdo_q, tdo_d;
    logic        irUpd, drUpd, shiftOn, sel, dataHit;

    assign irUpd   = updB_q[2] & ~updC_q[2] & ~syncB_q[3];
    assign drUpd   = updB_q[1] & ~updC_q[1];
    assign shiftOn = syncB_q[3];
    assign sel     = debugActive & isAccessInstr(ir_q);
    assign ioHit   = (ioAddr == CommRegAddr) & debugEnableFuse & ioEn_q;

    // Range mode uses slot B as a mask over slot A
    always_comb begin
        if (rangeMode_q) begin
            dataHit = brkEn_q[0] & (((dataAddr ^ brkA_q) & brkB_q) == '0);
        end else begin
            dataHit = (brkEn_q[0] & (dataAddr == brkA_q)) |
                      (brkEn_q[1] & (dataAddr == brkB_q));
        end
    end

    always_comb begin
        shift_d     = shift_q;
        ir_d        = ir_q;
        comm_d      = comm_q;
        dirty_d     = dirty_q;
        ioEn_d      = ioEn_q;
        halt_d      = halt_q;
        rangeMode_d = rangeMode_q;
        brkEn_d     = brkEn_q;
        brkA_d      = brkA_q;
        brkB_d      = brkB_q;
        tdo_d       = tdo_q;
        if (irUpd) begin
            ir_d = shift_q[17:14];
        end
        if (shiftOn & tckRise) begin
            shift_d = {syncB_q[0], shift_q[17:1]};
        end
        if (shiftOn & tckFall) begin
            tdo_d = shift_q[0];
        end
        // Capture feeds the comm byte back, so the debugger reads it next scan
        if (drUpd & sel) begin
            case (shift_q[1:0])
                CmdReadComm: begin
                    dirty_d = 1'b0;
                end
                CmdWriteBrk: begin
                    if (shift_q[17]) brkB_d = {1'b0, shift_q[16:2]};
                    else brkA_d = {1'b0, shift_q[16:2]};
                end
                CmdCtrl: begin
                    ioEn_d      = shift_q[2];
                    rangeMode_d = shift_q[3];
                    brkEn_d     = shift_q[5:4];
                    halt_d      = shift_q[6];
                end
                default: begin
                    shift_d = {8'h00, dirty_q, comm_q, 1'b0};
                end
            endcase
        end
        if ((breakInstr | (dataAccess & dataHit)) & debugActive) begin
            halt_d = 1'b1;
        end
        // Set wins over a same-cycle clear from the debugger
        if (ioWr & ioHit) begin
            comm_d  = ioWdata;
            dirty_d = 1'b1;
        end
        if (!debugActive) begin
            halt_d = 1'b0;
            ioEn_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shift_q     <= 18'h00000;
            ir_q        <= 4'hf;
            comm_q      <= CommRegReset;
            dirty_q     <= 1'b0;
            ioEn_q      <= 1'b0;
            halt_q      <= 1'b0;
            rangeMode_q <= 1'b0;
            brkEn_q     <= 2'h0;
            brkA_q      <= 16'h0000;
            brkB_q      <= 16'h0000;
            tdo_q       <= 1'b0;
        end else begin
            shift_q     <= shift_d;
            ir_q        <= ir_d;
            comm_q      <= comm_d;
            dirty_q     <= dirty_d;
            ioEn_q      <= ioEn_d;
            halt_q      <= halt_d;
            rangeMode_q <= rangeMode_d;
            brkEn_q     <= brkEn_d;
            brkA_q      <= brkA_d;
            brkB_q      <= brkB_d;
            tdo_q       <= tdo_d;
        end
    end

    assign ioRdata        = ioHit ? {dirty_q, comm_q[DirtyBit-1:0]} : 8'h00;
    assign tdo            = tdo_q;
    assign tdoEn          = tapEnabled & shiftOn & sel;
    assign debugAccessSel = sel;
    assign cpuHalt        = halt_q;
endmodule // onchip_debug_channel
`default_nettype wire

// ### sim/debug_chk.sv
`default_nettype none
module debug_chk (
    // Watched ports
    input wire logic clk, srst, jtagPortFuse, debugEnableFuse, ioWr, ioHit, breakInstr,
    input wire logic tapEnabled, debugActive, debugAccessSel, cpuHalt,
    input wire logic [1:0] lockBits,
    input wire logic [5:0] ioAddr,
    input wire logic [7:0] ioWdata, ioRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence wrHit; ioWr && ioHit; endsequence
    tap_gate_a: assert property (tapEnabled == jtagPortFuse) else $error("tap gate");
    debug_gate_a: assert property (debugActive == (tapEnabled && debugEnableFuse && !lockBits))
        else $error("debug gate");
    sel_gate_a: assert property (debugAccessSel |-> debugActive) else $error("sel gate");
    byte_pass_a: assert property (wrHit ##1 ioHit |-> ioRdata == {1'h1, $past(ioWdata[6:0])})
        else $error("byte pass");
    read_mask_a: assert property (!ioHit |-> ioRdata == 8'h00) else $error("read mask");
    hit_gate_a: assert property (ioHit |-> ioAddr == 6'h22 && debugEnableFuse) else $error("hit gate");
    break_halt_a: assert property (breakInstr && debugActive |-> ##[1:2] cpuHalt) else $error("no halt");
    halt_cause_a: assert property ($rose(cpuHalt) |-> $past(debugActive)) else $error("stray halt");
endmodule // debug_chk
bind onchip_debug_channel debug_chk debug_chk_inst (.*);
`default_nettype wire

// ### sim/dbg_model.sv
`default_nettype none
module dbg_model (
    // Debugger pins and TAP levels
    output logic        tck, tdi, drShift, drUpdate, irUpdate,
    // Read-back of the device's scan output
    input  wire logic   tdo, tdoEn,
    output logic [17:0] rdBack
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {tck, tdi, drShift, drUpdate, irUpdate, rdBack} = 23'h0;
    task automatic xfer(input logic [17:0] w, input logic toIr);
        drShift = 1'h1;
        for (int i = 0; i < 18; i++) begin
            tdi = w[i];
            #40 tck = 1'h1;
            // An undriven line reads inverted, so a missing enable spoils the word
            rdBack = {tdoEn ? tdo : ~tdo, rdBack[17:1]};
            #40 tck = 1'h0;
        end
        // Released line flips so a stale bit never passes for data
        {drShift, tdi} = {1'h0, ~tdi};
        {irUpdate, drUpdate} = {toIr, !toIr};
        #80 {irUpdate, drUpdate} = 2'h0;
        #80;
    endtask
    task automatic clear_dirty();
        xfer(18'h0, 1'h0);
    endtask
endmodule // dbg_model
`default_nettype wire

// ### sim/tb_onchip_debug_channel.sv
`default_nettype none
module tb_onchip_debug_channel;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, srst = 1'h1, tms = 1'h0, ioRd = 1'h0, ioWr = 1'h0, breakInstr = 1'h0, dataAccess = 1'h0;
    logic jtagPortFuse = 1'h1, debugEnableFuse = 1'h1, tck, tdi, irUpdate, drShift, drUpdate, tdo, tdoEn, ioHit;
    logic tapEnabled, debugActive, debugAccessSel, cpuHalt;
    logic [1:0] lockBits = 2'h0;
    logic [5:0] ioAddr = 6'h22;
    logic [7:0] ioWdata = 8'h00, ioRdata;
    logic [15:0] dataAddr = 16'h0;
    logic [17:0] rdBack;
    logic [5:0] rows [5] = '{6'h33, 6'h22, 6'h10, 6'h36, 6'h3a};
    int failures = 0, n_tests = 0;
    always #5 clk = ~clk;
    onchip_debug_channel onchip_debug_channel_inst (.*);
    dbg_model dbg_model_inst (.tck, .tdi, .drShift, .drUpdate, .irUpdate, .tdo, .tdoEn, .rdBack);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) failures++;
        if (seen !== exp) $display("mismatch t=%0t got %h exp %h", $time, seen, exp);
    endtask
    task automatic drv(input logic [2:0] s, logic [15:0] a, logic [7:0] d, logic h);
        {ioWr, breakInstr, dataAccess, dataAddr, ioWdata} = {s, a, d};
        cyc(1);
        {ioWr, breakInstr, dataAccess} = 3'h0;
        cyc(2);
        chk({7'h0, cpuHalt}, {7'h0, h});
    endtask
    task automatic summarize();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000 failures++;
        summarize();
    end
    initial begin
        cyc(10);
        srst = 1'h0;
        chk(ioRdata | {tdo, cpuHalt, ioHit, 5'h0}, 8'h00);
        foreach (rows[i]) begin
            {jtagPortFuse, debugEnableFuse, lockBits} = rows[i][5:2];
            cyc(1);
            chk({6'h0, tapEnabled, debugActive}, {6'h0, rows[i][1:0]});
        end
        lockBits = 2'h0;
        for (int c = 6; c < 12; c++) begin
            dbg_model_inst.xfer({c[3:0], 14'h0}, 1'h1);
            chk({7'h0, debugAccessSel}, {7'h0, c > 7});
        end
        dbg_model_inst.xfer(18'h16, 1'h0);
        drv(3'h4, 16'h0, 8'ha5, 1'h0);
        chk(ioRdata, 8'ha5);
        dbg_model_inst.clear_dirty();
        chk(ioRdata, 8'h25);
        drv(3'h2, 16'h0, 8'h00, 1'h1);
        dbg_model_inst.xfer(18'h12, 1'h0);
        dbg_model_inst.xfer(18'h8d1, 1'h0);
        drv(3'h1, 16'h0235, 8'h00, 1'h0);
        drv(3'h1, 16'h0234, 8'h00, 1'h1);
        dbg_model_inst.xfer(18'h3ffc1, 1'h0);
        dbg_model_inst.xfer(18'h1e, 1'h0);
        drv(3'h1, 16'h0244, 8'h00, 1'h0);
        drv(3'h1, 16'h023b, 8'h00, 1'h1);
        dbg_model_inst.xfer(18'h26, 1'h0);
        drv(3'h1, 16'h0234, 8'h00, 1'h0);
        drv(3'h1, 16'h7ff0, 8'h00, 1'h1);
        dbg_model_inst.xfer(18'h16, 1'h0);
        drv(3'h4, 16'h0, 8'h3c, 1'h0);
        chk(ioRdata, 8'hbc);
        dbg_model_inst.xfer(18'h3, 1'h0);
        dbg_model_inst.clear_dirty();
        chk(rdBack[8:1], 8'h3c);
        chk({7'h0, rdBack[9]}, 8'h01);
        chk({7'h0, tdoEn}, 8'h00);
        chk(ioRdata, 8'h3c);
        drv(3'h2, 16'h0, 8'h00, 1'h1);
        srst = 1'h1;
        cyc(1);
        srst = 1'h0;
        chk({4'h0, ioHit, cpuHalt, debugAccessSel, tdoEn}, 8'h00);
        summarize();
    end
endmodule // tb_onchip_debug_channel
`default_nettype wire
